// ### verilog/srp_reg_map.sv
// apb register bank of the sensor map with burst pointer
//
// What this block does
// - fast-read with hybrid wrap moves the pointer to 0x33 after the last Z byte.
// - fast-read without hybrid wrap moves the pointer to 0x00 after the Z byte.
// - each axis high byte holds the eight top bits of its 14-bit sample.
// - each axis low byte holds the six bottom bits of the sample.
// - trigger configuration is read/write at 0x0A; bursts then step to 0x0B.
//
// Added by the designer: the APB register port.
module srp_reg_map (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sample_valid,
  input wire logic [13:0] accel_x,
  input wire logic [13:0] accel_y,
  input wire logic [13:0] accel_z,
  input wire logic [7:0] data_ready_status,
  input wire logic [7:0] fifo_status,
  input wire logic [7:0] system_mode_in,
  input wire logic [7:0] interrupt_cause_in,
  output logic [1:0] fifo_mode,
  output logic [7:0] fifo_setup,
  output logic [7:0] fifo_trigger_config,
  output logic [7:0] range_filter_config,
  output logic [7:0] filter_cutoff_select,
  output logic fast_read,
  output logic hybrid_pointer_wrap
);

  logic [13:0] x_q;
  logic [13:0] x_d;
  logic [13:0] y_q;
  logic [13:0] y_d;
  logic [13:0] z_q;
  logic [13:0] z_d;
  logic [7:0] fsetup_q;
  logic [7:0] fsetup_d;
  logic [7:0] trig_q;
  logic [7:0] trig_d;
  logic [7:0] range_q;
  logic [7:0] range_d;
  logic [7:0] cutoff_q;
  logic [7:0] cutoff_d;
  logic [7:0] ptr_q;
  logic [7:0] ptr_d;
  logic [1:0] ctrl_q;
  logic [1:0] ctrl_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [9:0] idx;
  logic setup_ph;
  logic access_ph;
  logic in_map;
  logic is_ptr;
  logic is_win;
  logic is_ctrl;
  logic mapped;
  logic wr_ok;
  logic [7:0] wr_addr;
  logic [7:0] next_ptr;
  logic [31:0] word_rd;

  // byte of the sensor map at a given offset; outside the map reads zero
  function automatic logic [7:0] byte_at(input logic [7:0] a, input logic [7:0] st, input logic [13:0] sx,
                                         input logic [13:0] sy, input logic [13:0] sz, input logic [7:0] fs,
                                         input logic [7:0] tg, input logic [7:0] sm, input logic [7:0] ic,
                                         input logic [7:0] rg, input logic [7:0] co);
    logic [7:0] b;
    b = 8'h00;
    unique case (a)
      srp_pkg::IDX_SAMPLE_STATUS: b = st;
      srp_pkg::IDX_ACCEL_X_HIGH: b = sx[13:6];
      srp_pkg::IDX_ACCEL_X_LOW: b = {sx[5:0], 2'h0};
      srp_pkg::IDX_ACCEL_Y_HIGH: b = sy[13:6];
      srp_pkg::IDX_ACCEL_Y_LOW: b = {sy[5:0], 2'h0};
      srp_pkg::IDX_ACCEL_Z_HIGH: b = sz[13:6];
      srp_pkg::IDX_ACCEL_Z_LOW: b = {sz[5:0], 2'h0};
      srp_pkg::IDX_RESERVED_GAP, srp_pkg::IDX_RESERVED_END: b = srp_pkg::RST_RESERVED;
      srp_pkg::IDX_FIFO_SETUP: b = fs;
      srp_pkg::IDX_FIFO_TRIGGER_CONFIG: b = tg;
      srp_pkg::IDX_SYSTEM_MODE_STATE: b = sm;
      srp_pkg::IDX_INTERRUPT_CAUSE: b = ic;
      srp_pkg::IDX_DEVICE_IDENTITY: b = srp_pkg::DEVICE_IDENTITY_VALUE;
      srp_pkg::IDX_RANGE_FILTER_CONFIG: b = rg;
      srp_pkg::IDX_FILTER_CUTOFF_SELECT: b = co;
      default: b = 8'h00;
    endcase
    return b;
  endfunction : byte_at

  // apb phase and address decode
  assign idx = paddr[11:2];
  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable;
  assign in_map = (idx[9:4] == 6'h00);
  assign is_ptr = (idx == srp_pkg::IDX_POINTER);
  assign is_win = (idx == srp_pkg::IDX_DATA_WINDOW);
  assign is_ctrl = (idx == srp_pkg::IDX_POINTER_CTRL);
  assign mapped = in_map | is_ptr | is_win | is_ctrl;

  // zero wait states: read data was captured during the setup cycle
  assign pready = access_ph;
  assign pslverr = access_ph & ~mapped;
  assign prdata = rdata_q;

  // sample status shows fifo state once a fifo mode is set
  logic [7:0] status_byte;
  assign fifo_mode = fsetup_q[srp_pkg::FIFO_MODE_MSB:srp_pkg::FIFO_MODE_LSB];
  assign status_byte = (fifo_mode != 2'h0) ? fifo_status : data_ready_status;

  // burst pointer step
  srp_next_addr u_next (
    .addr(ptr_q),
    .fifo_active(fifo_mode != 2'h0),
    .fast_read(ctrl_q[srp_pkg::CTRL_FAST_READ_BIT]),
    .hybrid_pointer_wrap(ctrl_q[srp_pkg::CTRL_HYBRID_WRAP_BIT]),
    .next_addr(next_ptr)
  );

  // word presented for a read; the window reads the byte under the pointer
  always_comb
  begin
    word_rd = 32'h0000_0000;
    if (is_win)
      word_rd = {24'h00_0000, byte_at(ptr_q, status_byte, x_q, y_q, z_q, fsetup_q, trig_q, system_mode_in,
                                      interrupt_cause_in, range_q, cutoff_q)};
    else if (is_ptr)
      word_rd = {24'h00_0000, ptr_q};
    else if (is_ctrl)
      word_rd = {30'h0000_0000, ctrl_q};
    else if (in_map)
      word_rd = {24'h00_0000, byte_at(idx[7:0], status_byte, x_q, y_q, z_q, fsetup_q, trig_q, system_mode_in,
                                      interrupt_cause_in, range_q, cutoff_q)};
  end

  // only lane 0 carries data; other lanes are ignored
  assign wr_ok = access_ph & pwrite & pstrb[0] & mapped;
  assign wr_addr = is_win ? ptr_q : idx[7:0];

  // next state of the register file and pointer
  always_comb
  begin
    x_d = x_q;
    y_d = y_q;
    z_d = z_q;
    fsetup_d = fsetup_q;
    trig_d = trig_q;
    range_d = range_q;
    cutoff_d = cutoff_q;
    ptr_d = ptr_q;
    ctrl_d = ctrl_q;
    rdata_d = rdata_q;
    // a whole sample set is taken at once so high and low bytes stay paired
    if (sample_valid)
    begin
      x_d = accel_x;
      y_d = accel_y;
      z_d = accel_z;
    end
    if (setup_ph && !pwrite)
      rdata_d = word_rd;
    if (wr_ok && (in_map || is_win))
    begin
      unique case (wr_addr)
        srp_pkg::IDX_FIFO_SETUP: fsetup_d = pwdata[7:0];
        srp_pkg::IDX_FIFO_TRIGGER_CONFIG: trig_d = pwdata[7:0];
        srp_pkg::IDX_RANGE_FILTER_CONFIG: range_d = pwdata[7:0];
        srp_pkg::IDX_FILTER_CUTOFF_SELECT: cutoff_d = pwdata[7:0];
        default: trig_d = trig_q;
      endcase
    end
    if (wr_ok && is_ctrl)
      ctrl_d = pwdata[1:0];
    // each window byte steps the pointer; a pointer write restarts the burst
    if (access_ph && is_win && (pstrb[0] || !pwrite))
      ptr_d = next_ptr;
    if (wr_ok && is_ptr)
      ptr_d = pwdata[7:0];
  end

  // registers
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      x_q <= srp_pkg::RST_SAMPLE;
      y_q <= srp_pkg::RST_SAMPLE;
      z_q <= srp_pkg::RST_SAMPLE;
      fsetup_q <= srp_pkg::RST_FIFO_SETUP;
      trig_q <= srp_pkg::RST_FIFO_TRIGGER_CONFIG;
      range_q <= srp_pkg::RST_RANGE_FILTER_CONFIG;
      cutoff_q <= srp_pkg::RST_FILTER_CUTOFF_SELECT;
      ptr_q <= srp_pkg::RST_POINTER;
      ctrl_q <= srp_pkg::RST_POINTER_CTRL;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      x_q <= x_d;
      y_q <= y_d;
      z_q <= z_d;
      fsetup_q <= fsetup_d;
      trig_q <= trig_d;
      range_q <= range_d;
      cutoff_q <= cutoff_d;
      ptr_q <= ptr_d;
      ctrl_q <= ctrl_d;
      rdata_q <= rdata_d;
    end
  end

  // configuration outputs straight from flops
  assign fifo_setup = fsetup_q;
  assign fifo_trigger_config = trig_q;
  assign range_filter_config = range_q;
  assign filter_cutoff_select = cutoff_q;
  assign fast_read = ctrl_q[srp_pkg::CTRL_FAST_READ_BIT];
  assign hybrid_pointer_wrap = ctrl_q[srp_pkg::CTRL_HYBRID_WRAP_BIT];

  // window read completing at a given pointer
  logic win_rd;
  assign win_rd = access_ph & is_win & ~pwrite;

  // checks on pointer movement and data layout
  hyb_wrap_a: assert property (
    @(posedge clk) disable iff (!rstn)
    win_rd && fast_read && hybrid_pointer_wrap &&
    (ptr_q == srp_pkg::IDX_ACCEL_Z_HIGH || ptr_q == srp_pkg::IDX_ACCEL_Z_LOW)
    |=> ptr_q == srp_pkg::ADDR_MAG_DATA)
  else $error("pointer did not move to magnetometer data");

  zero_wrap_a: assert property (
    @(posedge clk) disable iff (!rstn)
    win_rd && fast_read && !hybrid_pointer_wrap && ptr_q == srp_pkg::IDX_ACCEL_Z_HIGH
    |=> ptr_q == srp_pkg::ADDR_WRAP_ZERO)
  else $error("pointer did not wrap to zero");

  high_byte_a: assert property (
    @(posedge clk) disable iff (!rstn)
    setup_ph && !pwrite && idx == {2'h0, srp_pkg::IDX_ACCEL_Y_HIGH}
    |=> prdata == {24'h00_0000, $past(y_q[13:6])} && pready)
  else $error("y high byte does not hold top sample bits");

  low_byte_a: assert property (
    @(posedge clk) disable iff (!rstn)
    setup_ph && !pwrite && idx == {2'h0, srp_pkg::IDX_ACCEL_X_LOW}
    |=> prdata[7:2] == $past(x_q[5:0]) && prdata[1:0] == 2'h0)
  else $error("x low byte does not hold bottom sample bits");

  trig_step_a: assert property (
    @(posedge clk) disable iff (!rstn)
    access_ph && is_win && ptr_q == srp_pkg::IDX_FIFO_TRIGGER_CONFIG && (pstrb[0] || !pwrite)
    |=> ptr_q == srp_pkg::IDX_SYSTEM_MODE_STATE)
  else $error("pointer did not step past trigger configuration");

  trig_write_a: assert property (
    @(posedge clk) disable iff (!rstn)
    wr_ok && idx == {2'h0, srp_pkg::IDX_FIFO_TRIGGER_CONFIG}
    |=> fifo_trigger_config == $past(pwdata[7:0]))
  else $error("trigger configuration write lost");

  ptr_load_a: assert property (
    @(posedge clk) disable iff (!rstn)
    wr_ok && is_ptr |=> ptr_q == $past(pwdata[7:0]))
  else $error("start pointer not loaded");

  ptr_hold_a: assert property (
    @(posedge clk) disable iff (!rstn)
    !(access_ph && (is_win || is_ptr)) |=> $stable(ptr_q))
  else $error("pointer moved without a byte transfer");

  unmapped_err_a: assert property (
    @(posedge clk) disable iff (!rstn)
    access_ph && idx[9:6] != 4'h0 |-> pslverr && pready)
  else $error("unmapped access not flagged");

  // burst steps in each mode; a wrong step silently returns the wrong axis byte
  plain_step_a: assert property (
    @(posedge clk) disable iff (!rstn)
    win_rd && !fast_read && fifo_mode == 2'h0 && ptr_q == srp_pkg::IDX_ACCEL_X_HIGH
    |=> ptr_q == srp_pkg::IDX_ACCEL_X_LOW)
  else $error("plain burst did not step to x low byte");

  fast_skip_a: assert property (
    @(posedge clk) disable iff (!rstn)
    win_rd && fast_read && fifo_mode == 2'h0 && ptr_q == srp_pkg::IDX_ACCEL_X_HIGH
    |=> ptr_q == srp_pkg::IDX_ACCEL_Y_HIGH)
  else $error("fast read did not skip the x low byte");

  fifo_park_a: assert property (
    @(posedge clk) disable iff (!rstn)
    win_rd && fifo_mode != 2'h0 && ptr_q == srp_pkg::IDX_ACCEL_X_HIGH
    |=> ptr_q == srp_pkg::IDX_ACCEL_X_HIGH)
  else $error("fifo mode did not park on x high byte");

  win_write_a: assert property (
    @(posedge clk) disable iff (!rstn)
    access_ph && is_win && pwrite && pstrb[0] && ptr_q == srp_pkg::IDX_FILTER_CUTOFF_SELECT
    |=> filter_cutoff_select == $past(pwdata[7:0]))
  else $error("window write did not reach the cutoff byte");

  // read data must stand from one read setup to the next
  rdata_hold_a: assert property (
    @(posedge clk) disable iff (!rstn)
    !(setup_ph && !pwrite)
    |=> $stable(prdata))
  else $error("read data changed outside a read setup");

endmodule : srp_reg_map

// ### verilog/srp_pkg.sv
// constants for the sensor register pointer map
package srp_pkg;

  // byte offsets of the sensor map; they are register indices, apb byte address is four times
  localparam logic [7:0] IDX_SAMPLE_STATUS = 8'h00;
  localparam logic [7:0] IDX_ACCEL_X_HIGH = 8'h01;
  localparam logic [7:0] IDX_ACCEL_X_LOW = 8'h02;
  localparam logic [7:0] IDX_ACCEL_Y_HIGH = 8'h03;
  localparam logic [7:0] IDX_ACCEL_Y_LOW = 8'h04;
  localparam logic [7:0] IDX_ACCEL_Z_HIGH = 8'h05;
  localparam logic [7:0] IDX_ACCEL_Z_LOW = 8'h06;
  localparam logic [7:0] IDX_RESERVED_GAP = 8'h07;
  localparam logic [7:0] IDX_RESERVED_END = 8'h08;
  localparam logic [7:0] IDX_FIFO_SETUP = 8'h09;
  localparam logic [7:0] IDX_FIFO_TRIGGER_CONFIG = 8'h0A;
  localparam logic [7:0] IDX_SYSTEM_MODE_STATE = 8'h0B;
  localparam logic [7:0] IDX_INTERRUPT_CAUSE = 8'h0C;
  localparam logic [7:0] IDX_DEVICE_IDENTITY = 8'h0D;
  localparam logic [7:0] IDX_RANGE_FILTER_CONFIG = 8'h0E;
  localparam logic [7:0] IDX_FILTER_CUTOFF_SELECT = 8'h0F;
  localparam logic [7:0] IDX_MAP_LAST = 8'h0F;

  // host-side access registers
  localparam logic [9:0] IDX_POINTER = 10'h020;
  localparam logic [9:0] IDX_DATA_WINDOW = 10'h021;
  localparam logic [9:0] IDX_POINTER_CTRL = 10'h022;
  localparam int CTRL_FAST_READ_BIT = 0;
  localparam int CTRL_HYBRID_WRAP_BIT = 1;

  // pointer targets of the wrap
  localparam logic [7:0] ADDR_WRAP_ZERO = 8'h00;
  localparam logic [7:0] ADDR_MAG_DATA = 8'h33;

  // field of the fifo setup byte holding the fifo mode
  localparam int FIFO_MODE_MSB = 7;
  localparam int FIFO_MODE_LSB = 6;

  // sample layout
  localparam int SAMPLE_W = 14;
  localparam int LOW_PAD_W = 2;

  // values after reset
  localparam logic [7:0] RST_FIFO_SETUP = 8'h00;
  localparam logic [7:0] RST_FIFO_TRIGGER_CONFIG = 8'h00;
  localparam logic [7:0] RST_RANGE_FILTER_CONFIG = 8'h00;
  localparam logic [7:0] RST_FILTER_CUTOFF_SELECT = 8'h00;
  localparam logic [7:0] RST_RESERVED = 8'h00;
  localparam logic [7:0] RST_POINTER = 8'h00;
  localparam logic [1:0] RST_POINTER_CTRL = 2'h0;
  localparam logic [13:0] RST_SAMPLE = 14'h0000;

  // identity byte; the value is arbitrary
  localparam logic [7:0] DEVICE_IDENTITY_VALUE = 8'h5A;

endpackage : srp_pkg

// ### verilog/srp_next_addr.sv
// next-address mapping of the burst pointer
module srp_next_addr (
  input wire logic [7:0] addr,
  input wire logic fifo_active,
  input wire logic fast_read,
  input wire logic hybrid_pointer_wrap,
  output logic [7:0] next_addr
);

  logic [7:0] z_wrap;

  // end of the fast-read acceleration block
  assign z_wrap = hybrid_pointer_wrap ? srp_pkg::ADDR_MAG_DATA : srp_pkg::ADDR_WRAP_ZERO;

  // low bytes are skipped in fast-read; fifo mode parks on the x high byte
  always_comb
  begin
    next_addr = addr + 8'h01;
    unique case (addr)
      srp_pkg::IDX_ACCEL_X_HIGH:
      begin
        if (fifo_active)
          next_addr = srp_pkg::IDX_ACCEL_X_HIGH;
        else if (fast_read)
          next_addr = srp_pkg::IDX_ACCEL_Y_HIGH;
      end
      srp_pkg::IDX_ACCEL_X_LOW, srp_pkg::IDX_ACCEL_Y_LOW:
      begin
        if (fast_read)
          next_addr = srp_pkg::ADDR_WRAP_ZERO;
      end
      srp_pkg::IDX_ACCEL_Y_HIGH:
      begin
        if (fast_read && fifo_active)
          next_addr = srp_pkg::ADDR_WRAP_ZERO;
        else if (fast_read)
          next_addr = srp_pkg::IDX_ACCEL_Z_HIGH;
      end
      srp_pkg::IDX_ACCEL_Z_HIGH:
      begin
        if (fast_read)
          next_addr = z_wrap;
      end
      srp_pkg::IDX_ACCEL_Z_LOW:
      begin
        next_addr = z_wrap;
      end
      default:
      begin
        next_addr = addr + 8'h01;
      end
    endcase
  end

endmodule : srp_next_addr

// ### verification/srp_host_model.sv
// host model: apb master issuing single-word register transfers
module srp_host_model (
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus from time zero
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
  end

  // one transfer; starts one edge late so a release never meets a new setup in one step
  task xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hF;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // request held until pready is seen at an edge; no latency assumed
    while (pready !== 1'b1)
      @(posedge clk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : srp_host_model

// ### verification/srp_reg_map_tb.sv
// self-checking bench of the sensor register map
module srp_reg_map_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] A_PTR = {srp_pkg::IDX_POINTER, 2'b00};
  localparam logic [11:0] A_WIN = {srp_pkg::IDX_DATA_WINDOW, 2'b00};
  localparam logic [11:0] A_CTRL = {srp_pkg::IDX_POINTER_CTRL, 2'b00};
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, fast_read, hybrid_pointer_wrap, err;
  logic sample_valid = 1'b0;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] pstrb;
  logic [13:0] axes [3] = '{14'h2ABC, 14'h1357, 14'h3FC1};
  logic [13:0] accel_x = 14'h0;
  logic [13:0] accel_y = 14'h0;
  logic [13:0] accel_z = 14'h0;
  logic [7:0] dr_st = 8'h3C;
  logic [7:0] ff_st = 8'hC5;
  logic [7:0] sm_in = 8'h02;
  logic [7:0] ic_in = 8'h81;
  logic [1:0] fifo_mode;
  logic [7:0] fifo_setup, fifo_trigger_config, range_filter_config, filter_cutoff_select;
  int failures = 0;
  int cmp_count = 0;
  int cycles = 0;

  srp_host_model host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  srp_reg_map dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_valid(sample_valid), .accel_x(accel_x), .accel_y(accel_y), .accel_z(accel_z),
    .data_ready_status(dr_st), .fifo_status(ff_st), .system_mode_in(sm_in), .interrupt_cause_in(ic_in),
    .fifo_mode(fifo_mode), .fifo_setup(fifo_setup), .fifo_trigger_config(fifo_trigger_config),
    .range_filter_config(range_filter_config), .filter_cutoff_select(filter_cutoff_select),
    .fast_read(fast_read), .hybrid_pointer_wrap(hybrid_pointer_wrap));

  // 100 MHz clock
  initial
  begin
    forever #5 clk = ~clk;
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    host.xfer(1'b0, a, 32'h0, q, err);
    cmp(q, exp);
    cmp({31'h0, err}, 32'h0);
  endtask : rd_chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q, err);
    // outputs update at the write edge; look once they have settled
    @(negedge clk);
  endtask : wr

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  // hang guard; the whole sequence needs well under a thousand cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      report_and_stop();
    end
  end

  initial
  begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    // reset values, identity, live inputs, reserved and read-only places
    rd_chk(12'h038, 32'h0);
    rd_chk(12'h03C, 32'h0);
    rd_chk(12'h01C, 32'h0);
    wr(12'h034, 32'hFF);
    rd_chk(12'h034, {24'h0, srp_pkg::DEVICE_IDENTITY_VALUE});
    rd_chk(12'h02C, {24'h0, sm_in});
    rd_chk(12'h030, {24'h0, ic_in});
    wr(12'h038, 32'h12);
    rd_chk(12'h038, 32'h12);
    cmp({24'h0, range_filter_config}, 32'h12);
    // unmapped index is refused with an error and no data
    host.xfer(1'b0, 12'h100, 32'h0, q, err);
    cmp({31'h0, err}, 32'h1);
    cmp(q, 32'h0);
    // one sample latched on all three axes, then split into high and low bytes
    @(posedge clk);
    accel_x <= axes[0];
    accel_y <= axes[1];
    accel_z <= axes[2];
    sample_valid <= 1'b1;
    @(posedge clk);
    sample_valid <= 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      rd_chk(12'h004 + 12'(8 * i), {24'h0, axes[i][13:6]});
      rd_chk(12'h008 + 12'(8 * i), {24'h0, axes[i][5:0], 2'b00});
    end
    // plain burst walks all six bytes and wraps to the status byte
    wr(A_PTR, 32'h01);
    for (int j = 0; j < 6; j++)
      rd_chk(A_WIN, j[0] ? {24'h0, axes[j / 2][5:0], 2'b00} : {24'h0, axes[j / 2][13:6]});
    rd_chk(A_PTR, 32'h0);
    // fast read skips low bytes and wraps to zero without hybrid wrap
    wr(A_CTRL, 32'h1);
    cmp({31'h0, fast_read}, 32'h1);
    wr(A_PTR, 32'h01);
    for (int k = 0; k < 3; k++)
      rd_chk(A_WIN, {24'h0, axes[k][13:6]});
    rd_chk(A_PTR, 32'h0);
    // hybrid wrap moves on to the magnetic data after the last z byte
    wr(A_CTRL, 32'h3);
    cmp({31'h0, hybrid_pointer_wrap}, 32'h1);
    wr(A_PTR, 32'h05);
    rd_chk(A_WIN, {24'h0, axes[2][13:6]});
    rd_chk(A_PTR, 32'h33);
    // trigger config is read/write and always steps to 0x0B, in all four pointer control settings with fifo mode 0 and 2
    wr(12'h028, 32'hA5);
    cmp({24'h0, fifo_trigger_config}, 32'hA5);
    for (int c = 0; c < 8; c++)
    begin
      wr(12'h024, {24'h0, c[2], 7'h0});
      cmp({24'h0, fifo_setup}, {24'h0, c[2], 7'h0});
      wr(A_CTRL, {30'h0, c[1:0]});
      wr(A_PTR, 32'h0A);
      rd_chk(A_WIN, 32'hA5);
      rd_chk(A_PTR, 32'h0B);
    end
    // last loop pass leaves fifo mode 2 set, which switches the status byte source
    cmp({30'h0, fifo_mode}, 32'h2);
    // fifo mode parks the burst on the x high byte
    wr(A_PTR, 32'h01);
    rd_chk(A_WIN, {24'h0, axes[0][13:6]});
    rd_chk(A_PTR, 32'h01);
    rd_chk(12'h000, {24'h0, ff_st});
    wr(12'h024, 32'h0);
    rd_chk(12'h000, {24'h0, dr_st});
    // window write lands at the pointer and steps it
    wr(A_PTR, 32'h0F);
    wr(A_WIN, 32'h3C);
    cmp({24'h0, filter_cutoff_select}, 32'h3C);
    rd_chk(A_PTR, 32'h10);
    report_and_stop();
  end
endmodule : srp_reg_map_tb
